// [emb_defs.svh]
/*
  Constants of the external memory bus interface: register offsets, field
  positions, reset values, configuration codes, pin positions and timing.
  Assumes inclusion by its bare name from the package and the design modules.
*/
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH

// Register offsets on the plain register port
`define EMB_CTRL_OFS      8'h00
`define EMB_STAT_OFS      8'h01

// Control register layout
`define EMB_CTRL_RST      8'h00
`define EMB_CTRL_MASK     8'hB3
`define EMB_RELEASE_BIT   7
`define EMB_WAIT_HI       5
`define EMB_WAIT_LO       4
`define EMB_WM_HI         1
`define EMB_WM_LO         0

// Address width configuration codes
`define EMB_ABW_20        2'h0
`define EMB_ABW_16        2'h1
`define EMB_ABW_12        2'h2
`define EMB_ABW_INT       2'h3

// Write mode codes (bit 1 set means word write)
`define EMB_WM_BYTE_SEL   2'h1
`define EMB_WM_BYTE_WR    2'h0

// Control strobe positions on port J
`define EMB_J_ALE         0
`define EMB_J_OE          1
`define EMB_J_WRL         2
`define EMB_J_WRH         3
`define EMB_J_BA0         4
`define EMB_J_CE          5
`define EMB_J_LB          6
`define EMB_J_UB          7

// Flattened pin vector: D at 7:0, E at 15:8, H at 19:16, J at 27:20
`define EMB_PIN_W         28
`define EMB_E_LSB         8
`define EMB_H_LSB         16
`define EMB_J_LSB         20

// One wait unit is one instruction cycle
`define EMB_CLK_PERIOD_NS 100
`define EMB_TCY_NS        100
`define EMB_TCY_CYCLES    ((`EMB_TCY_NS + `EMB_CLK_PERIOD_NS - 1) / `EMB_CLK_PERIOD_NS)

`endif

// [emb_pkg.sv]
/*
  Types of the external memory bus interface.
  Assumes emb_defs.svh is on the include path.
*/
`default_nettype none
`include "emb_defs.svh"

package emb_pkg;

  // Gray codes along idle, address, hold, data, wait, end
  typedef enum logic [2:0] {
    EMB_IDLE = 3'h0,
    EMB_ADDR = 3'h1,
    EMB_HOLD = 3'h3,
    EMB_DATA = 3'h2,
    EMB_WAIT = 3'h6,
    EMB_END  = 3'h7
  } emb_state_e;

  typedef logic [`EMB_PIN_W-1:0] emb_pins_t;
  typedef logic [1:0]            emb_code_t;

endpackage : emb_pkg

`default_nettype wire

// [emb_pin_if.sv]
/*
  Carrier between the bus controller and its pin multiplexer.
  Assumes the flattened pin layout of emb_defs.svh.
*/
`default_nettype none
`include "emb_defs.svh"

interface emb_pin_if;
  import emb_pkg::*;

  emb_pins_t own;
  emb_pins_t bus_out;
  emb_pins_t bus_oe;

  modport ctl (output own, output bus_out, output bus_oe);
  modport mux (input own, input bus_out, input bus_oe);

endinterface : emb_pin_if

`default_nettype wire

// [emb_pinmux.sv]
/*
  Pin multiplexer: each pin is driven by the bus where the bus owns it and by
  the port logic otherwise, through one register stage.
  Assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
`include "emb_defs.svh"

module emb_pinmux
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Controller side
  emb_pin_if.mux            pins,
  // Port logic side
  input  wire emb_pkg::emb_pins_t port_out,
  input  wire emb_pkg::emb_pins_t port_oe,
  // Pads
  output var  emb_pkg::emb_pins_t pin_out,
  output var  emb_pkg::emb_pins_t pin_oe
);
  import emb_pkg::*;

  genvar i;
  generate
    for (i = 0; i < `EMB_PIN_W; i = i + 1)
    begin : g_pin
      // Bus wins over every other function sharing the pin
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          pin_out[i] <= 1'b0;
          pin_oe[i]  <= 1'b0;
        end
        else
        begin
          pin_out[i] <= pins.own[i] ? pins.bus_out[i] : port_out[i];
          pin_oe[i]  <= pins.own[i] ? pins.bus_oe[i] : port_oe[i];
        end
      end
    end
  endgenerate

endmodule : emb_pinmux

`default_nettype wire

// [emb_ctrl.sv]
/*
  External memory bus controller: control register, access sequencer,
  strobe generation, line ownership and read capture.
  Assumes configuration straps stable around reset, and requests from the
  core's fetch and table logic on a start pulse.
*/
// The register addresses and the plain strobed port were left to the implementer.
// Functional notes
// - Eight or sixteen data bits, three address widths
// - Shared lines on ports D, E, H
// - Strobes on port J in fixed order
// - Internal-only mode ignores control register writes
// - Release bit clear: bus owns pins always
// - Release bit set: bus takes pins on access
// - Release bit resets to zero
// - Wait field adds zero to three cycles
// - Word write outputs full word, write-high
// - Byte select copies byte, write-high plus select
// - Byte write copies byte, write-high or write-low
// - Write mode ignored with eight-bit data
// - Unused control bits read zero
// - Variant without bus reads control as zero
// - Strap selects data width, set means sixteen
// - Strap selects address width or internal mode
// - Freed high lines stay port I/O
// - Twelve-bit address hides upper data bits
// - Address and data share the same lines
// - Latch strobe marks address, then output enable
// - Idle bus floats lines, strobes at rest
// - Chip enable low during access, high asleep
`default_nettype none
`include "emb_defs.svh"

module emb_ctrl
(
  // Clock and reset
  input  wire logic               REF_CLK,
  input  wire logic               SYS_RST,
  // Configuration straps
  input  wire logic               CFG_BUS_PRESENT,
  input  wire logic               CFG_DATA_WIDE,
  input  wire emb_pkg::emb_code_t CFG_ADDR_WIDTH,
  // Core status
  input  wire logic               CORE_SLEEP,
  input  wire logic               CORE_EXEC_EXT,
  // Register port
  input  wire logic [7:0]         REG_ADDR,
  input  wire logic [7:0]         REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output var  logic [7:0]         REG_RDATA,
  // Access requests
  input  wire logic               ACC_START,
  input  wire logic               ACC_WRITE,
  input  wire logic               ACC_FETCH,
  input  wire logic [20:0]        ACC_ADDR,
  input  wire logic [7:0]         ACC_LATCH,
  output var  logic               ACC_BUSY,
  output var  logic               ACC_DONE,
  output var  logic [15:0]        ACC_RDATA,
  // Port logic sharing the pins
  input  wire emb_pkg::emb_pins_t GPIO_OUT,
  input  wire emb_pkg::emb_pins_t GPIO_OE,
  // Pads
  input  wire logic [7:0]         PORT_D_PINS_IN,
  output var  logic [7:0]         PORT_D_PINS_OUT,
  output var  logic [7:0]         PORT_D_PINS_OE,
  input  wire logic [7:0]         PORT_E_PINS_IN,
  output var  logic [7:0]         PORT_E_PINS_OUT,
  output var  logic [7:0]         PORT_E_PINS_OE,
  output var  logic [3:0]         PORT_H_PINS_OUT,
  output var  logic [3:0]         PORT_H_PINS_OE,
  output var  logic [7:0]         PORT_J_PINS_OUT,
  output var  logic [7:0]         PORT_J_PINS_OE
);
  import emb_pkg::*;

  // Port E lines that carry bus signals at a given address width
  function automatic logic [7:0] e_lines(input emb_code_t abw);
    e_lines = (abw == `EMB_ABW_12) ? 8'h0F : 8'hFF;
  endfunction : e_lines

  emb_state_e state;
  emb_code_t  cfg_abw;
  logic       cfg_wide;
  logic       cfg_present;
  logic [7:0] bus_control_reg;
  logic       eff_release;
  logic [3:0] wait_cnt;
  logic       op_write;
  logic       op_skip;
  logic [19:0] op_addr;
  logic       op_ba0;
  logic [15:0] op_data;
  logic       op_wrl;
  logic       op_wrh;
  logic       op_lb;
  logic       op_ub;
  logic [7:0] held_lo;
  logic       ext_mode;
  logic       bus_ok;
  logic       acc_take;
  logic       word_even;
  logic       engaged;
  logic [1:0] wide_write_mode;
  logic [3:0] next_waits;
  logic       addr_phase;
  logic       data_phase;
  logic [7:0] e_mask;
  emb_pins_t  own_mask;
  emb_pins_t  pin_out;
  emb_pins_t  pin_oe;

  emb_pin_if pins ();

  // Straps are caught while reset is held; software cannot change them
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      cfg_abw     <= CFG_ADDR_WIDTH;
      cfg_wide    <= CFG_DATA_WIDE;
      cfg_present <= CFG_BUS_PRESENT;
    end
  end

  assign ext_mode        = cfg_present && (cfg_abw != `EMB_ABW_INT);
  assign wide_write_mode = bus_control_reg[`EMB_WM_HI:`EMB_WM_LO];
  assign bus_ok          = ext_mode && !CORE_SLEEP;
  assign acc_take        = (state == EMB_IDLE) && ACC_START;
  assign word_even       = ACC_WRITE && cfg_wide && wide_write_mode[1] && !ACC_ADDR[0];
  assign e_mask          = e_lines(cfg_abw);
  assign next_waits      = ACC_FETCH ? 4'h0 :
                           4'((2'h3 - bus_control_reg[`EMB_WAIT_HI:`EMB_WAIT_LO])
                              * `EMB_TCY_CYCLES);

  // Control register; writes dropped in internal mode or without the bus
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      bus_control_reg <= `EMB_CTRL_RST;
    else if (REG_WR && (REG_ADDR == `EMB_CTRL_OFS) && ext_mode)
      bus_control_reg <= REG_WDATA & `EMB_CTRL_MASK;
  end

  // Setting the release bit from external code waits for internal execution
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      eff_release <= 1'b0;
    else if (!CORE_EXEC_EXT)
      eff_release <= bus_control_reg[`EMB_RELEASE_BIT];
  end

  // Register reads answer one cycle later and read zero otherwise
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      REG_RDATA <= 8'h00;
    else if (REG_RD && (REG_ADDR == `EMB_CTRL_OFS))
      REG_RDATA <= cfg_present ? bus_control_reg : 8'h00;
    else if (REG_RD && (REG_ADDR == `EMB_STAT_OFS))
      REG_RDATA <= {5'h00, eff_release, engaged, ACC_BUSY};
    else
      REG_RDATA <= 8'h00;
  end

  // Access sequencer
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      state <= EMB_IDLE;
    else
    begin
      unique case (state)
        EMB_IDLE:
          if (acc_take)
            state <= (!bus_ok || word_even) ? EMB_END : EMB_ADDR;
        EMB_ADDR:
          state <= EMB_HOLD;
        EMB_HOLD:
          state <= EMB_DATA;
        EMB_DATA:
          state <= (wait_cnt == 4'h0) ? EMB_END : EMB_WAIT;
        EMB_WAIT:
          if (wait_cnt == 4'h1)
            state <= EMB_END;
        EMB_END:
          state <= EMB_IDLE;
        default:
          state <= EMB_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      wait_cnt <= 4'h0;
    else if (acc_take)
      wait_cnt <= next_waits;
    else if (state == EMB_WAIT)
      wait_cnt <= wait_cnt - 4'h1;
  end

  // Operation capture: address, data image and strobes per write mode
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      op_write <= 1'b0;
      op_skip  <= 1'b0;
      op_addr  <= 20'h00000;
      op_ba0   <= 1'b0;
      op_data  <= 16'h0000;
      op_wrl   <= 1'b0;
      op_wrh   <= 1'b0;
      op_lb    <= 1'b0;
      op_ub    <= 1'b0;
    end
    else if (acc_take)
    begin
      op_write <= ACC_WRITE;
      op_skip  <= !bus_ok || word_even;
      op_addr  <= cfg_wide ? ACC_ADDR[20:1] : ACC_ADDR[19:0];
      op_ba0   <= ACC_ADDR[0];
      op_data  <= {ACC_LATCH, ACC_LATCH};
      op_wrl   <= 1'b0;
      op_wrh   <= 1'b0;
      op_lb    <= !ACC_WRITE;
      op_ub    <= !ACC_WRITE;
      if (ACC_WRITE && !cfg_wide)
        op_wrl <= 1'b1;
      else if (ACC_WRITE && wide_write_mode[1])
      begin
        op_data <= {ACC_LATCH, held_lo};
        op_wrh  <= 1'b1;
        op_lb   <= 1'b1;
        op_ub   <= 1'b1;
      end
      else if (ACC_WRITE && (wide_write_mode == `EMB_WM_BYTE_SEL))
      begin
        op_wrh <= 1'b1;
        op_ub  <= ACC_ADDR[0];
        op_lb  <= !ACC_ADDR[0];
      end
      else if (ACC_WRITE)
      begin
        op_wrh <= ACC_ADDR[0];
        op_wrl <= !ACC_ADDR[0];
      end
    end
  end

  // Low byte of a word write waits here for its high byte
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      held_lo <= 8'h00;
    else if (acc_take && word_even)
      held_lo <= ACC_LATCH;
  end

  // Memory drives the lines only under output enable, so capture at end
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      ACC_RDATA <= 16'h0000;
    else if (state == EMB_END)
    begin
      if (op_write || op_skip)
        ACC_RDATA <= 16'h0000;
      else if (cfg_wide)
        ACC_RDATA <= {PORT_E_PINS_IN & e_mask, PORT_D_PINS_IN};
      else
        ACC_RDATA <= {8'h00, PORT_D_PINS_IN};
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      ACC_DONE <= 1'b0;
      ACC_BUSY <= 1'b0;
    end
    else
    begin
      ACC_DONE <= (state == EMB_END);
      if (acc_take)
        ACC_BUSY <= 1'b1;
      else if (state == EMB_END)
        ACC_BUSY <= 1'b0;
    end
  end

  // Line ownership; freed high lines never follow the release bit
  assign engaged = ext_mode &&
                   (!eff_release || (state != EMB_IDLE) || CORE_EXEC_EXT);
  assign own_mask = {8'hFF, {4{cfg_abw == `EMB_ABW_20}}, e_mask, 8'hFF};
  assign pins.own = engaged ? own_mask : '0;

  assign addr_phase = (state == EMB_ADDR) || (state == EMB_HOLD);
  assign data_phase = (state == EMB_DATA) || (state == EMB_WAIT);

  // Address then data on the same lines; idle lines float, strobes rest
  always_comb
  begin
    pins.bus_out = '0;
    pins.bus_oe  = '0;
    if (addr_phase)
    begin
      pins.bus_out[15:0] = op_addr[15:0];
      pins.bus_oe[15:0]  = 16'hFFFF;
    end
    else if (data_phase)
    begin
      pins.bus_out[15:0] = cfg_wide ? op_data : {op_addr[15:8], op_data[7:0]};
      pins.bus_oe[7:0]   = {8{op_write}};
      pins.bus_oe[15:8]  = cfg_wide ? {8{op_write}} : 8'hFF;
    end
    if (addr_phase || data_phase)
    begin
      pins.bus_out[19:16] = op_addr[19:16];
      pins.bus_oe[19:16]  = 4'hF;
    end
    pins.bus_oe[27:20] = 8'hFF;
    pins.bus_out[`EMB_J_LSB + `EMB_J_ALE] = (state == EMB_ADDR);
    pins.bus_out[`EMB_J_LSB + `EMB_J_OE]  = !(data_phase && !op_write);
    pins.bus_out[`EMB_J_LSB + `EMB_J_WRL] = !(data_phase && op_wrl);
    pins.bus_out[`EMB_J_LSB + `EMB_J_WRH] = !(data_phase && op_wrh);
    pins.bus_out[`EMB_J_LSB + `EMB_J_BA0] = (addr_phase || data_phase) && op_ba0;
    pins.bus_out[`EMB_J_LSB + `EMB_J_CE]  =
      !((addr_phase || data_phase) && !CORE_SLEEP);
    pins.bus_out[`EMB_J_LSB + `EMB_J_LB]  = !(data_phase && op_lb);
    pins.bus_out[`EMB_J_LSB + `EMB_J_UB]  = !(data_phase && op_ub);
  end

  emb_pinmux u_pinmux
  (
    .clk      (REF_CLK),
    .rst      (SYS_RST),
    .pins     (pins.mux),
    .port_out (GPIO_OUT),
    .port_oe  (GPIO_OE),
    .pin_out  (pin_out),
    .pin_oe   (pin_oe)
  );

  assign PORT_D_PINS_OUT = pin_out[7:0];
  assign PORT_D_PINS_OE  = pin_oe[7:0];
  assign PORT_E_PINS_OUT = pin_out[15:8];
  assign PORT_E_PINS_OE  = pin_oe[15:8];
  assign PORT_H_PINS_OUT = pin_out[19:16];
  assign PORT_H_PINS_OE  = pin_oe[19:16];
  assign PORT_J_PINS_OUT = pin_out[27:20];
  assign PORT_J_PINS_OE  = pin_oe[27:20];

endmodule : emb_ctrl

`default_nettype wire

// [emb_ctrl_chk.sv]
/*
  Port checker of the external memory bus controller.
  Assumes one clock, synchronous active-high reset, bound to emb_ctrl.
*/
`default_nettype none

module emb_ctrl_chk
(
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // Observed ports
  input wire logic        CORE_SLEEP,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        ACC_BUSY,
  input wire logic        ACC_DONE,
  input wire logic [15:0] ACC_RDATA,
  input wire logic [7:0]  PORT_D_PINS_OE,
  input wire logic [7:0]  PORT_J_PINS_OUT,
  input wire logic [7:0]  PORT_J_PINS_OE
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  wire logic ce_low = PORT_J_PINS_OE[5] && !PORT_J_PINS_OUT[5];
  wire logic oe_low = PORT_J_PINS_OE[1] && !PORT_J_PINS_OUT[1];
  wire logic wr_low = PORT_J_PINS_OE[2] && !(PORT_J_PINS_OUT[2] && PORT_J_PINS_OUT[3]);
  wire logic ale_hi = PORT_J_PINS_OE[0] && PORT_J_PINS_OUT[0];
  wire logic bus_idle = !ACC_BUSY && PORT_J_PINS_OE[0];

  sequence s_ale_rise;
    !ale_hi ##1 ale_hi;
  endsequence
  // Address phase: one cycle of latch strobe, chip held enabled
  sequence s_addr_phase;
    ce_low ##1 (ce_low && !ale_hi) ##1 ce_low;
  endsequence

  AST_ALE_CE: assert property (s_ale_rise |-> s_addr_phase)
    else $error("latch strobe not followed by address phase");
  AST_DONE_PULSE: assert property (ACC_DONE |=> !ACC_DONE)
    else $error("done longer than one cycle");
  AST_BUSY_DONE: assert property ($fell(ACC_BUSY) |-> ACC_DONE)
    else $error("busy fell without done");
  AST_ACC_BOUND: assert property ($rose(ACC_BUSY) |-> ##[1:7] ACC_DONE)
    else $error("access longer than three waits");
  AST_RDATA_HOLD: assert property (!ACC_DONE |-> $stable(ACC_RDATA))
    else $error("read data changed without done");
  AST_REG_QUIET: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("register data without read");
  AST_IDLE_REST: assert property (bus_idle && !$past(ACC_BUSY) |-> PORT_J_PINS_OUT == 8'hEE)
    else $error("idle strobes not at rest");
  AST_IDLE_FLOAT: assert property (bus_idle && !$past(ACC_BUSY) |-> PORT_D_PINS_OE == 8'h00)
    else $error("idle data lines driven");
  AST_READ_FLOAT: assert property (oe_low |-> PORT_D_PINS_OE == 8'h00)
    else $error("lines driven while memory outputs");
  AST_WRITE_DRIVE: assert property (wr_low |-> !oe_low && PORT_D_PINS_OE == 8'hFF)
    else $error("write strobe without driven data");
  AST_SLEEP_CE: assert property (CORE_SLEEP && $past(CORE_SLEEP) && !ACC_BUSY |-> !ce_low)
    else $error("chip enabled while asleep");
endmodule : emb_ctrl_chk

bind emb_ctrl emb_ctrl_chk emb_ctrl_chk_i (.REF_CLK, .SYS_RST, .CORE_SLEEP, .REG_RD, .REG_RDATA,
  .ACC_BUSY, .ACC_DONE, .ACC_RDATA, .PORT_D_PINS_OE, .PORT_J_PINS_OUT, .PORT_J_PINS_OE);

`default_nettype wire

// [emb_mem_model.sv]
/*
  Behavioural multiplexed memory on the far side of the bus.
  Assumes pad values as the controller drives them; no pull-ups enabled.
*/
`default_nettype none

module emb_mem_model
(
  // Clock
  input  wire logic        clk,
  // Pads seen by the memory
  input  wire logic [7:0]  d_out,
  input  wire logic [7:0]  e_out,
  input  wire logic [3:0]  h_out,
  input  wire logic [7:0]  j_out,
  input  wire logic [7:0]  j_oe,
  output logic [7:0]       d_in,
  output logic [7:0]       e_in,
  // Observations
  output logic [19:0]      lat_addr,
  output logic [15:0]      wr_data,
  output logic [7:0]       wr_j
);
  logic [15:0] last = 16'h0000;
  logic        drive;

  // Answers only while selected and output enabled
  assign drive = j_oe[1] && !j_out[1] && !j_out[5];
  // Released lines show the inverse so a stale value cannot pass
  always_comb {e_in, d_in} = drive ? (lat_addr[15:0] ^ 16'h5A3C) : ~last;

  always_ff @(posedge clk)
  begin
    if (drive)
      last <= {e_in, d_in};
    if (j_oe[0] && j_out[0])
      lat_addr <= {h_out, e_out, d_out};
    if (j_oe[2] && !(j_out[2] && j_out[3]))
    begin
      wr_data <= {e_out, d_out};
      wr_j <= j_out;
    end
  end
endmodule : emb_mem_model

`default_nettype wire

// [emb_ctrl_tb_top.sv]
/*
  Self-checking bench of the bus controller with a memory model.
  Assumes emb_defs.svh on the include path and the checker bound.
*/
`default_nettype none
`include "emb_defs.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module emb_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import emb_pkg::*;

  localparam emb_pins_t gp_out = 28'h5A3C96E;
  localparam emb_pins_t gp_oe  = 28'hF0F0F0F;
  logic clk = 1'b0, rst, present, wide, sleep, reg_wr, reg_rd, start, wr, fetch, busy, done;
  logic        ext;
  emb_code_t abw;
  logic [7:0]  reg_addr, wdata, rdata, latch, d_in, e_in, d_out, d_oe, e_out, e_oe;
  logic [7:0]  j_out, j_oe, wr_j, rv;
  logic [3:0]  h_out, h_oe;
  logic [20:0] addr, a;
  logic [15:0] acc_rdata, wr_data;
  logic [19:0] lat_addr;
  int          err_total, checks_done, n;

  always #50 clk = ~clk;

  emb_ctrl emb_ctrl_i (.REF_CLK(clk), .SYS_RST(rst), .CFG_BUS_PRESENT(present),
    .CFG_DATA_WIDE(wide), .CFG_ADDR_WIDTH(abw), .CORE_SLEEP(sleep), .CORE_EXEC_EXT(ext),
    .REG_ADDR(reg_addr), .REG_WDATA(wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(rdata), .ACC_START(start), .ACC_WRITE(wr), .ACC_FETCH(fetch),
    .ACC_ADDR(addr), .ACC_LATCH(latch), .ACC_BUSY(busy), .ACC_DONE(done),
    .ACC_RDATA(acc_rdata), .GPIO_OUT(gp_out), .GPIO_OE(gp_oe), .PORT_D_PINS_IN(d_in),
    .PORT_D_PINS_OUT(d_out), .PORT_D_PINS_OE(d_oe), .PORT_E_PINS_IN(e_in),
    .PORT_E_PINS_OUT(e_out), .PORT_E_PINS_OE(e_oe), .PORT_H_PINS_OUT(h_out),
    .PORT_H_PINS_OE(h_oe), .PORT_J_PINS_OUT(j_out), .PORT_J_PINS_OE(j_oe));

  emb_mem_model emb_mem_model_i (.clk(clk), .d_out(d_out), .e_out(e_out), .h_out(h_out),
    .j_out(j_out), .j_oe(j_oe), .d_in(d_in), .e_in(e_in), .lat_addr(lat_addr),
    .wr_data(wr_data), .wr_j(wr_j));

  task automatic tally_and_finish;
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic do_reset(input logic w, input emb_code_t c, input logic p);
    @(posedge clk);
    rst <= 1'b1;
    wide <= w;
    abw <= c;
    present <= p;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic reg_write(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : reg_read

  // Cycles are counted from the edge that takes the request
  task automatic access(input logic w, input logic f, input logic [20:0] ad,
                        input logic [7:0] l, output int cyc);
    @(posedge clk);
    start <= 1'b1;
    wr <= w;
    fetch <= f;
    addr <= ad;
    latch <= l;
    @(posedge clk);
    start <= 1'b0;
    cyc = 0;
    do
    begin
      @(negedge clk);
      cyc++;
    end
    while (done !== 1'b1 && cyc < 20);
    if (done !== 1'b1)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask : access

  initial
  begin
    {rst, present, wide, sleep, reg_wr, reg_rd, start, wr, fetch, ext} = 10'h380;
    {abw, reg_addr, wdata, addr, latch} = '0;
    err_total = 0;
    checks_done = 0;
    do_reset(1'b1, `EMB_ABW_20, 1'b1);
    @(negedge clk);
    `CHK("idle strobes", 8'hEE, j_out)
    `CHK("strobe owner", 8'hFF, j_oe)
    `CHK("data float", 8'h00, d_oe)
    reg_read(`EMB_CTRL_OFS, rv);
    `CHK("ctrl reset", `EMB_CTRL_RST, rv)
    reg_write(`EMB_CTRL_OFS, 8'hFF);
    reg_read(`EMB_CTRL_OFS, rv);
    `CHK("ctrl unused", 8'hB3, rv)
    reg_read(8'h7F, rv);
    `CHK("unmapped", 8'h00, rv)
    for (int w = 0; w < 4; w++)
    begin
      reg_write(`EMB_CTRL_OFS, 8'(w << 4));
      a = 21'h1ACE0 + 21'(w * 2);
      access(1'b0, 1'b0, a, 8'h00, n);
      `CHK("wait cycles", 8 - w, n)
      `CHK("read word", a[16:1] ^ 16'h5A3C, acc_rdata)
      `CHK("bus address", a[20:1], lat_addr)
    end
    access(1'b0, 1'b1, 21'h00040, 8'h00, n);
    `CHK("fetch cycles", 5, n)
    reg_write(`EMB_CTRL_OFS, 8'h30);
    access(1'b1, 1'b0, 21'h00100, 8'h3C, n);
    `CHK("byte write data", 16'h3C3C, wr_data)
    `CHK("one strobe", 1'b1, wr_j[2] ^ wr_j[3])
    reg_write(`EMB_CTRL_OFS, 8'h31);
    access(1'b1, 1'b0, 21'h00103, 8'h7E, n);
    `CHK("select data", 16'h7E7E, wr_data)
    `CHK("select strobes", 2'b01, {wr_j[3], wr_j[6] ^ wr_j[7]})
    `CHK("byte address", 1'b1, wr_j[4])
    reg_write(`EMB_CTRL_OFS, 8'h32);
    access(1'b1, 1'b0, 21'h00200, 8'h11, n);
    `CHK("word even", 2, n)
    access(1'b1, 1'b0, 21'h00201, 8'h22, n);
    `CHK("word data", 16'h2211, wr_data)
    `CHK("word strobe", 1'b0, wr_j[3])
    reg_write(`EMB_CTRL_OFS, 8'hB0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("released", {gp_oe[27:20], gp_out[7:0]}, {j_oe, d_out})
    access(1'b0, 1'b0, 21'h02468, 8'h00, n);
    `CHK("taken read", 16'h1234 ^ 16'h5A3C, acc_rdata)
    @(posedge clk);
    ext <= 1'b1;
    reg_read(`EMB_STAT_OFS, rv);
    `CHK("external status", 8'h06, rv)
    `CHK("external owns", 8'hFF, j_oe)
    @(posedge clk);
    ext <= 1'b0;
    reg_write(`EMB_CTRL_OFS, 8'h30);
    @(posedge clk);
    sleep <= 1'b1;
    access(1'b0, 1'b0, 21'h00010, 8'h00, n);
    `CHK("sleep refused", {32'd2, 16'h0000}, {n, acc_rdata})
    @(posedge clk);
    sleep <= 1'b0;
    do_reset(1'b0, `EMB_ABW_16, 1'b1);
    @(negedge clk);
    `CHK("high lines free", {gp_oe[19:16], gp_out[19:16]}, {h_oe, h_out})
    reg_write(`EMB_CTRL_OFS, 8'h32);
    access(1'b0, 1'b0, 21'h01235, 8'h00, n);
    `CHK("narrow read", 8'h35 ^ 8'h3C, acc_rdata[7:0])
    access(1'b1, 1'b0, 21'h01236, 8'h4B, n);
    `CHK("narrow write", {32'd5, 8'h4B, 1'b0}, {n, wr_data[7:0], wr_j[2]})
    do_reset(1'b1, `EMB_ABW_12, 1'b1);
    access(1'b0, 1'b0, 21'h02468, 8'h00, n);
    `CHK("twelve bit read", {4'h0, 12'h234 ^ 12'hA3C}, acc_rdata)
    `CHK("upper e free", gp_out[15:12], e_out[7:4])
    do_reset(1'b1, `EMB_ABW_INT, 1'b1);
    reg_write(`EMB_CTRL_OFS, 8'h30);
    reg_read(`EMB_CTRL_OFS, rv);
    `CHK("internal ctrl", 8'h00, rv)
    access(1'b0, 1'b0, 21'h00010, 8'h00, n);
    `CHK("internal refused", 2, n)
    do_reset(1'b1, `EMB_ABW_20, 1'b0);
    reg_write(`EMB_CTRL_OFS, 8'h30);
    reg_read(`EMB_CTRL_OFS, rv);
    `CHK("absent ctrl", 8'h00, rv)
    tally_and_finish();
  end
endmodule : emb_ctrl_tb_top

`default_nettype wire
